/* core/mbfgd_top.sv */
/*
 * modbus frame gap detector: rtu and ascii receive framing with one gap
 * timer, frame checks, read coils polling in master mode, registers, irq.
 * assumes a uart delivers received bytes as one-cycle rx_valid pulses and
 * takes transmit bytes with a valid/ready handshake.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbfgd_params.svh"
module mbfgd_top #(
	parameter logic [31:0] CHAR_GAP_CYC = 32'(`MB_US_TO_CYC(`MB_CHAR_GAP_US)),
	parameter logic [31:0] FRAME_REM_CYC =
		32'(`MB_US_TO_CYC(`MB_FRAME_GAP_US - `MB_CHAR_GAP_US)),
	parameter logic [31:0] ASCII_TO_CYC = 32'(`MB_US_TO_CYC(`MB_ASCII_TO_US)),
	parameter logic [31:0] POLL_CYC = 32'(`MB_US_TO_CYC(`MB_POLL_US))
) (
	input wire logic clk, // system clock, 100 mhz
	input wire logic rst_n, // sync reset, active low
	input wire logic rx_valid, // received byte pulse
	input wire logic [7:0] rx_data, // received byte
	input wire logic tx_ready, // uart takes tx byte
	output logic tx_valid_q, // tx byte offered
	output logic [7:0] tx_data_q, // tx byte
	input wire logic [4:0] addr, // register byte address
	input wire logic [31:0] wr_data, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output logic [31:0] rd_data_q, // read data, cycle after rd_en
	output logic handler_q, // valid frame pulse
	output logic irq_q // interrupt level
);
	// registers
	logic [31:0] ctrl_q; // mode and own address
	logic [31:0] ato_q; // ascii timeout in cycles
	logic [`MB_STAT_W-1:0] stat_q; // sticky events
	logic [`MB_STAT_W-1:0] mask_q; // interrupt enables
	logic [`MB_STAT_W-1:0] stat_d; // next status
	// receive state
	logic [7:0] cnt_q; // stored bytes
	logic [7:0] fa_q; // first byte, slave address
	logic [7:0] fc_q; // second byte, function code
	logic gap_err_q; // rtu gap flag
	logic asc_in_q; // ascii frame open
	logic asc_cr_q; // ascii cr seen
	logic asc_nib_q; // ascii high nibble held
	logic [3:0] asc_hi_q; // ascii high nibble
	// transmit state
	mbfgd_pkg::mbfgd_tx_t tx_st_q, tx_st_d; // sequencer
	logic [2:0] tx_idx_q, tx_idx_d; // byte index
	logic tx_nib_q, tx_nib_d; // ascii low nibble next
	logic tx_tail_q, tx_tail_d; // ascii cr lf phase
	logic tx_feed; // byte into tx checksum
	// sub-block outputs
	logic gap_exp, gap_run, poll_exp, poll_run;
	logic [15:0] rx_crc, tx_crc;
	logic [7:0] rx_sum, tx_sum;

	// mode decode
	wire [2:0] mode = ctrl_q[`MB_CTRL_MODE];
	wire [7:0] own_addr = ctrl_q[`MB_CTRL_OWN];
	wire is_rtu = (mode == `MB_MODE_RTU_M) || (mode == `MB_MODE_RTU_S);
	wire is_asc = (mode == `MB_MODE_ASC_M) || (mode == `MB_MODE_ASC_S);
	wire is_mst = (mode == `MB_MODE_RTU_M) || (mode == `MB_MODE_ASC_M);

	// ascii character classes
	wire ch_colon = (rx_data == `MB_CH_COLON);
	wire ch_cr = (rx_data == `MB_CH_CR);
	wire ch_lf = (rx_data == `MB_CH_LF);
	wire ch_dig = (rx_data >= `MB_CH_0) && (rx_data <= `MB_CH_9);
	wire ch_af = (rx_data >= `MB_CH_A) && (rx_data <= `MB_CH_F);
	wire [7:0] dig_off = rx_data - `MB_CH_0;
	wire [7:0] af_off = rx_data - `MB_CH_A + `MB_HEX_TEN;
	wire [3:0] hex_nib = ch_dig ? dig_off[3:0] : af_off[3:0];

	// rtu receive events
	wire rtu_rx = is_rtu && rx_valid;
	wire rtu_cerr = rtu_rx && gap_err_q;
	wire rtu_store = rtu_rx && !gap_err_q;
	wire rtu_exp = is_rtu && gap_exp && !rtu_rx;
	wire rtu_mark = rtu_exp && !gap_err_q && (cnt_q != 8'h00);
	wire rtu_done = rtu_exp && gap_err_q;

	// ascii receive events
	wire asc_rx = is_asc && rx_valid;
	wire asc_start = asc_rx && ch_colon;
	wire asc_act = asc_rx && !ch_colon && asc_in_q;
	wire asc_done = asc_act && ch_lf && asc_cr_q;
	wire asc_byte = asc_act && (ch_dig || ch_af) && asc_nib_q;
	wire asc_cerr = is_asc && gap_exp && asc_in_q && !asc_rx;

	// merged receive events
	wire char_err = rtu_cerr || asc_cerr;
	wire frame_done = rtu_done || asc_done;
	wire rx_clr = char_err || frame_done || asc_start;
	wire store = rtu_store || asc_byte;
	wire [7:0] store_val = is_rtu ? rx_data : {asc_hi_q, hex_nib};

	// gap timer control: one timer for both rtu decisions and the ascii timeout
	wire gap_load = rtu_store || rtu_mark || asc_start || (asc_act && !asc_done);
	wire gap_stop = char_err || frame_done || !(is_rtu || is_asc);
	wire [31:0] gap_val = is_asc ? ato_q : (rtu_mark ? FRAME_REM_CYC : CHAR_GAP_CYC);

	// frame checks
	wire len_ok = (cnt_q >= (is_rtu ? `MB_RTU_MIN_LEN : `MB_ASC_MIN_LEN));
	wire addr_ok = (fa_q == (is_mst ? `MB_POLL_SLAVE : own_addr));
	wire [31:0] fc_bits = `MB_SLV_FC_MASK >> fc_q[4:0];
	wire fc_slv = (fc_q < `MB_FC_LIMIT) && fc_bits[0];
	wire func_ok = is_mst ? (fc_q == `MB_FC_RD_COILS) : fc_slv;
	wire cks_ok = len_ok && (is_rtu ? (rx_crc == 16'h0000) : (rx_sum == 8'h00));
	wire frame_ok = frame_done && addr_ok && func_ok && cks_ok;

	// poll timer free-runs in master mode
	wire poll_load = is_mst && (poll_exp || !poll_run);
	wire tx_idle = (tx_st_q == mbfgd_pkg::TX_IDLE);
	wire poll_go = is_mst && poll_exp && tx_idle;

	// register decode
	wire sel_ctrl = (addr == `MB_REG_CTRL);
	wire sel_ato = (addr == `MB_REG_ATO);
	wire sel_stat = (addr == `MB_REG_STAT);
	wire sel_mask = (addr == `MB_REG_MASK);
	wire sel_info = (addr == `MB_REG_INFO);
	wire [`MB_STAT_W-1:0] ev;
	assign ev[`MB_ST_FRAME] = frame_ok;
	assign ev[`MB_ST_CHERR] = char_err;
	assign ev[`MB_ST_ADDR] = frame_done && !addr_ok;
	assign ev[`MB_ST_FUNC] = frame_done && !func_ok;
	assign ev[`MB_ST_CKS] = frame_done && !cks_ok;
	assign ev[`MB_ST_POLL] = poll_go;
	wire [`MB_STAT_W-1:0] w1c = (wr_en && sel_stat) ? wr_data[`MB_STAT_W-1:0] : '0;
	assign stat_d = (stat_q & ~w1c) | ev; // set wins over clear
	wire [31:0] info = {5'h00, ~tx_idle, asc_in_q, gap_err_q, fc_q, fa_q, cnt_q};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_q : sel_ato ? ato_q : sel_stat ? {26'h0, stat_q} :
		sel_mask ? {26'h0, mask_q} : sel_info ? info : 32'h0;

	// transmit byte and character selection
	wire [7:0] lrc = 8'h00 - tx_sum;
	wire [47:0] req_w = {`MB_POLL_SLAVE, `MB_FC_RD_COILS, `MB_COIL_START, `MB_COIL_QTY}; // first byte high
	wire [7:0] body_b = req_w[6'd47 - {tx_idx_q, 3'h0} -: 8]; // request byte at tx_idx_q
	wire [7:0] chk_b = is_asc ? lrc : ((tx_idx_q == 3'h0) ? tx_crc[7:0] : tx_crc[15:8]);
	wire [7:0] cur_b = (tx_st_q == mbfgd_pkg::TX_BODY) ? body_b : chk_b;
	wire [3:0] tx_nib = tx_nib_q ? cur_b[3:0] : cur_b[7:4];
	wire [7:0] hex_ch = (tx_nib < `MB_NIB_TEN) ? (`MB_CH_0 + {4'h0, tx_nib}) :
		(`MB_CH_A + {4'h0, tx_nib} - `MB_HEX_TEN);
	wire [7:0] tail_ch = (tx_idx_q == 3'h0) ? `MB_CH_CR : `MB_CH_LF;
	wire [7:0] cur_ch = (tx_st_q == mbfgd_pkg::TX_HEAD) ? `MB_CH_COLON :
		tx_tail_q ? tail_ch : (is_asc ? hex_ch : cur_b);
	wire tx_go = !tx_idle && (!tx_valid_q || tx_ready);
	wire byte_end = !is_asc || tx_nib_q;

	// gap timer
	mbfgd_timer #(.W(32)) u_gap_timer (.clk(clk), .rst_n(rst_n), .load(gap_load), .stop(gap_stop),
		.val(gap_val), .run(gap_run), .expire_q(gap_exp));

	// poll period timer
	mbfgd_timer #(.W(32)) u_poll_period_timer (.clk(clk), .rst_n(rst_n), .load(poll_load),
		.stop(!is_mst), .val(POLL_CYC), .run(poll_run), .expire_q(poll_exp));

	// receive checksum
	mbfgd_cks u_rx_cks (.clk(clk), .rst_n(rst_n), .clr(rx_clr), .en(store), .din(store_val),
		.crc_q(rx_crc), .sum_q(rx_sum));

	// transmit checksum
	mbfgd_cks u_tx_cks (.clk(clk), .rst_n(rst_n), .clr(poll_go), .en(tx_feed), .din(body_b),
		.crc_q(tx_crc), .sum_q(tx_sum));

	// transmit sequencer next state
	always_comb begin
		tx_st_d = tx_st_q;
		tx_idx_d = tx_idx_q;
		tx_nib_d = tx_nib_q;
		tx_tail_d = tx_tail_q;
		tx_feed = 1'b0;
		case (tx_st_q)
			mbfgd_pkg::TX_IDLE: begin
				tx_idx_d = 3'h0;
				tx_nib_d = 1'b0;
				tx_tail_d = 1'b0;
				if (poll_go) begin
					tx_st_d = is_asc ? mbfgd_pkg::TX_HEAD : mbfgd_pkg::TX_BODY;
				end
			end
			mbfgd_pkg::TX_HEAD: begin
				if (tx_go) begin
					tx_st_d = mbfgd_pkg::TX_BODY;
				end
			end
			mbfgd_pkg::TX_BODY: begin
				if (tx_go) begin
					tx_nib_d = !byte_end;
					if (byte_end) begin
						tx_feed = 1'b1;
						tx_idx_d = (tx_idx_q == `MB_REQ_LAST) ? 3'h0 : tx_idx_q + 3'h1;
						if (tx_idx_q == `MB_REQ_LAST) begin
							tx_st_d = mbfgd_pkg::TX_CHK;
						end
					end
				end
			end
			mbfgd_pkg::TX_CHK: begin
				if (tx_go) begin
					if (tx_tail_q) begin // ascii cr then lf
						tx_idx_d = tx_idx_q + 3'h1;
						if (tx_idx_q == `MB_TAIL_LAST) begin
							tx_st_d = mbfgd_pkg::TX_IDLE;
						end
					end else if (is_asc) begin // lrc as two chars
						tx_nib_d = !tx_nib_q;
						tx_tail_d = tx_nib_q;
					end else begin // crc low byte first
						tx_idx_d = tx_idx_q + 3'h1;
						if (tx_idx_q == `MB_CHK_LAST) begin
							tx_st_d = mbfgd_pkg::TX_IDLE;
						end
					end
				end
			end
			default: begin
				tx_st_d = mbfgd_pkg::TX_IDLE;
			end
		endcase
	end

	// transmit registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_st_q <= mbfgd_pkg::TX_IDLE;
			tx_idx_q <= 3'h0;
			tx_nib_q <= 1'b0;
			tx_tail_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			tx_st_q <= tx_st_d;
			tx_idx_q <= tx_idx_d;
			tx_nib_q <= tx_nib_d;
			tx_tail_q <= tx_tail_d;
			if (tx_go) begin
				tx_valid_q <= 1'b1;
				tx_data_q <= cur_ch;
			end else if (tx_ready) begin
				tx_valid_q <= 1'b0;
			end
		end
	end

	// rtu gap flag: set on first expiry, cleared by char or frame end
	always_ff @(posedge clk) begin
		if (!rst_n || !is_rtu) begin
			gap_err_q <= 1'b0;
		end else if (rtu_cerr || rtu_done) begin
			gap_err_q <= 1'b0;
		end else if (rtu_mark) begin
			gap_err_q <= 1'b1;
		end
	end

	// receive count and header bytes
	always_ff @(posedge clk) begin
		if (!rst_n || rx_clr) begin
			cnt_q <= 8'h00;
		end else if (store && (cnt_q != 8'hFF)) begin
			cnt_q <= cnt_q + 8'h01;
		end
		if (!rst_n) begin
			fa_q <= 8'h00;
			fc_q <= 8'h00;
		end else if (store) begin
			fa_q <= (cnt_q == 8'h00) ? store_val : fa_q;
			fc_q <= (cnt_q == 8'h01) ? store_val : fc_q;
		end
	end

	// ascii frame tracking
	always_ff @(posedge clk) begin
		if (!rst_n || !is_asc || asc_cerr || asc_done) begin
			asc_in_q <= 1'b0;
			asc_cr_q <= 1'b0;
			asc_nib_q <= 1'b0;
			asc_hi_q <= 4'h0;
		end else if (asc_start) begin
			asc_in_q <= 1'b1;
			asc_cr_q <= 1'b0;
			asc_nib_q <= 1'b0;
		end else if (asc_act) begin
			asc_cr_q <= ch_cr;
			if (ch_dig || ch_af) begin
				asc_nib_q <= !asc_nib_q;
				asc_hi_q <= hex_nib;
			end
		end
	end

	// software registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `MB_CTRL_RST;
			ato_q <= ASCII_TO_CYC;
			mask_q <= '0;
			stat_q <= '0;
		end else begin
			ctrl_q <= (wr_en && sel_ctrl) ? wr_data : ctrl_q;
			ato_q <= (wr_en && sel_ato) ? wr_data : ato_q;
			mask_q <= (wr_en && sel_mask) ? wr_data[`MB_STAT_W-1:0] : mask_q;
			stat_q <= stat_d;
		end
	end

	// read data, handler pulse and interrupt
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data_q <= 32'h0;
			handler_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rd_data_q <= rd_en ? rd_mux : 32'h0;
			handler_q <= frame_ok;
			irq_q <= |(stat_d & mask_q);
		end
	end
endmodule : mbfgd_top
`default_nettype wire

/* common/mbfgd_params.svh */
/*
 * constants of the modbus frame gap detector: timing, register map,
 * field positions, mode codes, characters and poll request bytes.
 * assumes a 100 mhz system clock and a byte-wide uart beside the block.
 */
`ifndef MBFGD_PARAMS_SVH
`define MBFGD_PARAMS_SVH

// clock rate and time conversion
`define MB_CLK_MHZ 100
`define MB_US_TO_CYC(us) ((us) * `MB_CLK_MHZ)
// gap = chars x 11 bits x 1/19200 s x 1.01 margin, in microseconds
`define MB_CHAR_GAP_US 868
`define MB_FRAME_GAP_US 2026
`define MB_ASCII_TO_US 1000000
`define MB_POLL_US 1000000

// register offsets (byte addresses)
`define MB_REG_CTRL 5'h00
`define MB_REG_ATO 5'h04
`define MB_REG_STAT 5'h08
`define MB_REG_MASK 5'h0C
`define MB_REG_INFO 5'h10
// register reset values
`define MB_CTRL_RST 32'h0000_0102
// control register fields
`define MB_CTRL_MODE 2:0
`define MB_CTRL_OWN 15:8
`define MB_STAT_W 6

// status bit positions
`define MB_ST_FRAME 0
`define MB_ST_CHERR 1
`define MB_ST_ADDR 2
`define MB_ST_FUNC 3
`define MB_ST_CKS 4
`define MB_ST_POLL 5

// mode codes
`define MB_MODE_RTU_M 3'h1
`define MB_MODE_RTU_S 3'h2
`define MB_MODE_ASC_M 3'h3
`define MB_MODE_ASC_S 3'h4

// ascii framing characters
`define MB_CH_COLON 8'h3A
`define MB_CH_CR 8'h0D
`define MB_CH_LF 8'h0A
`define MB_CH_0 8'h30
`define MB_CH_9 8'h39
`define MB_CH_A 8'h41
`define MB_CH_F 8'h46
`define MB_HEX_TEN 8'h0A
`define MB_NIB_TEN 4'hA

// frame checks
`define MB_RTU_MIN_LEN 8'h04
`define MB_ASC_MIN_LEN 8'h03
`define MB_SLV_FC_MASK 32'h0081_807E
`define MB_FC_LIMIT 8'h20
`define MB_CRC_INIT 16'hFFFF
`define MB_CRC_POLY 16'hA001

// poll request: read coils to slave 1
`define MB_POLL_SLAVE 8'h01
`define MB_FC_RD_COILS 8'h01
`define MB_COIL_START 16'h0000
`define MB_COIL_QTY 16'h0010
`define MB_REQ_LAST 3'h5
`define MB_CHK_LAST 3'h1
`define MB_TAIL_LAST 3'h1

`endif

/* common/mbfgd_pkg.sv */
/*
 * types of the modbus frame gap detector.
 * assumes mbfgd_params.svh supplies all numeric constants.
 */
`default_nettype none
package mbfgd_pkg;
	// transmit sequencer states, one-hot
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1, // nothing to send
		TX_HEAD = 4'h2, // ascii start colon
		TX_BODY = 4'h4, // request bytes
		TX_CHK = 4'h8 // crc or lrc
	} mbfgd_tx_t;
	// ascii trailer uses a flag beside TX_CHK
endpackage : mbfgd_pkg
`default_nettype wire

/* core/mbfgd_timer.sv */
/*
 * reloadable down counter with a one-cycle expiry pulse.
 * assumes load and stop are synchronous pulses; a load value of zero never expires.
 */
`timescale 1ns/1ps
`default_nettype none
module mbfgd_timer #(
	parameter int W = 32 // counter width
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic load, // start with val
	input wire logic stop, // halt and clear
	input wire logic [W-1:0] val, // period in cycles
	output logic run, // counting
	output logic expire_q // one-cycle expiry pulse
);
	logic [W-1:0] cnt_q; // remaining cycles
	wire last = (cnt_q == W'(1)); // final cycle of period

	assign run = (cnt_q != '0);

	// count down, load wins over stop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			expire_q <= 1'b0;
		end else begin
			expire_q <= last && !load && !stop;
			if (load) begin
				cnt_q <= val;
			end else if (stop) begin
				cnt_q <= '0;
			end else if (run) begin
				cnt_q <= cnt_q - W'(1);
			end
		end
	end
endmodule : mbfgd_timer
`default_nettype wire

/* core/mbfgd_cks.sv */
/*
 * running crc-16 and byte sum over a byte stream.
 * assumes clr and en never matter in the same cycle; clr wins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mbfgd_params.svh"
module mbfgd_cks (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, active low
	input wire logic clr, // restart both sums
	input wire logic en, // take din
	input wire logic [7:0] din, // data byte
	output logic [15:0] crc_q, // crc, zero over a good rtu frame
	output logic [7:0] sum_q // byte sum, zero over a good ascii frame
);
	logic [15:0] crc_d; // crc after din

	// bitwise reflected crc, low bit first
	always_comb begin
		crc_d = crc_q ^ {8'h00, din};
		for (int i = 0; i < 8; i++) begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ `MB_CRC_POLY) : (crc_d >> 1);
		end
	end

	// hold or advance both sums
	always_ff @(posedge clk) begin
		if (!rst_n || clr) begin
			crc_q <= `MB_CRC_INIT;
			sum_q <= 8'h00;
		end else if (en) begin
			crc_q <= crc_d;
			sum_q <= sum_q + din;
		end
	end
endmodule : mbfgd_cks
`default_nettype wire

/* tb/mbfgd_properties.sv */
/* port checker of the frame gap detector.
   assumes a bind onto mbfgd_top, handing on its gap parameters. */
`timescale 1ns/1ps
`default_nettype none
module mbfgd_properties #(
	parameter logic [31:0] CHAR_GAP_CYC = 32'h14, // char gap
	parameter logic [31:0] FRAME_REM_CYC = 32'h1E // frame rest
) (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire logic rx_valid, // rx strobe
	input wire logic [7:0] rx_data, // rx byte
	input wire logic tx_ready, // tx taken
	input wire logic tx_valid_q, // tx offered
	input wire logic [7:0] tx_data_q, // tx byte
	input wire logic wr_en, // write
	input wire logic rd_en, // read
	input wire logic [31:0] rd_data_q, // read data
	input wire logic handler_q, // frame ok
	input wire logic irq_q // interrupt
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [31:0] quiet_q; // cycles since last rx byte
	logic [31:0] quiet_d; // next count
	assign quiet_d = rx_valid ? 32'h0 : quiet_q + 32'h1;
	// silence counter
	always_ff @(posedge clk) begin
		quiet_q <= rst_n ? quiet_d : 32'h0;
	end
	chk_rd_quiet: assert property (!rd_en |=> rd_data_q == 32'h0)
		else $error("read data outside its slot");
	chk_tx_hold: assert property (tx_valid_q && !tx_ready |=> tx_valid_q)
		else $error("tx byte withdrawn");
	chk_tx_steady: assert property (tx_valid_q && !tx_ready |=> $stable(tx_data_q))
		else $error("tx byte changed while offered");
	chk_handler_pulse: assert property (handler_q |=> !handler_q)
		else $error("handler pulse too long");
	chk_frame_silence: assert property (handler_q |-> quiet_q >= CHAR_GAP_CYC + FRAME_REM_CYC
		|| ($past(rx_valid) && $past(rx_data) == 8'h0A))
		else $error("frame ended without silence or line end");
	chk_rx_no_end: assert property (rx_valid && rx_data != 8'h0A |=> !handler_q ##1
		(!handler_q || ($past(rx_valid) && $past(rx_data) == 8'h0A)) [*2])
		else $error("frame ended right after a byte");
	chk_irq_sticky: assert property (irq_q && !wr_en |=> irq_q)
		else $error("interrupt dropped without a write");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !tx_valid_q && !handler_q && !irq_q)
		else $error("outputs busy after reset");
	cov_frame: cover property (handler_q);
	cov_irq_clear: cover property (irq_q && wr_en);
	cov_tx: cover property (tx_valid_q && tx_ready);
endmodule : mbfgd_properties
bind mbfgd_top mbfgd_properties #(.CHAR_GAP_CYC(CHAR_GAP_CYC), .FRAME_REM_CYC(FRAME_REM_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
	.tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data_q(rd_data_q), .handler_q(handler_q), .irq_q(irq_q));
`default_nettype wire

/* tb/mbfgd_partner.sv */
/* far node model: feeds received bytes, takes sent bytes with stalls.
   assumes the bench drives stall and calls send. */
`timescale 1ns/1ps
`default_nettype none
module mbfgd_partner (
	input wire logic clk, // clock
	input wire logic stall, // hold off tx
	input wire logic tx_valid_q, // offered
	input wire logic [7:0] tx_data_q, // offered byte
	output logic tx_ready, // take byte
	output var logic rx_valid, // rx strobe
	output var logic [7:0] rx_data // rx byte
);
	logic [7:0] got[$]; // bytes taken from the device
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	assign tx_ready = !stall;
	// gather every byte handed over
	always @(posedge clk) begin
		if (tx_valid_q && tx_ready) begin
			got.push_back(tx_data_q);
		end
	end
	// one byte strobe; data line scrambled outside it
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask : send
endmodule : mbfgd_partner
`default_nettype wire

/* tb/testbench.sv */
/* self-checking bench of the frame gap detector.
   assumes short gap parameters so every silence lasts a few cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "mbfgd_params.svh"
module testbench;
	localparam logic [31:0] CG = 32'd20; // char gap
	localparam logic [31:0] FR = 32'd30; // frame rest
	localparam logic [31:0] AT = 32'd50; // ascii timeout
	localparam logic [31:0] PC = 32'd400; // poll period
	logic clk = 1'b0; // clock
	logic rst_n = 1'b0; // reset
	logic [4:0] addr = 5'h00; // bus address
	logic [31:0] wr_data = 32'h0; // bus data
	logic wr_en = 1'b0; // write strobe
	logic rd_en = 1'b0; // read strobe
	logic stall = 1'b0; // far side stall
	logic rd_seen = 1'b0; // read answer due
	logic rx_valid, tx_ready, tx_valid_q, handler_q, irq_q; // single bits
	logic [7:0] rx_data, tx_data_q; // bytes
	logic [31:0] rd_data_q; // read data
	logic [31:0] exp_q[$]; // expected read values
	logic [31:0] seed = 32'hA675; // xorshift state
	logic [7:0] fr[$]; // frame under test
	int n_errors = 0;
	int checks = 0;
	mbfgd_top #(.CHAR_GAP_CYC(CG), .FRAME_REM_CYC(FR), .ASCII_TO_CYC(AT), .POLL_CYC(PC)) dut (
		.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
		.tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .handler_q(handler_q), .irq_q(irq_q));
	mbfgd_partner u_far (.clk(clk), .stall(stall), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	always #5 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// reflected crc over a byte list
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = `MB_CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `MB_CRC_POLY : c >> 1;
		end
		return c;
	endfunction : crc16
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic give_verdict();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask : rd
	// bytes with random short gaps
	task automatic send_frame(input logic [7:0] q[$]);
		logic [31:0] g;
		foreach (q[i]) begin
			g = rnd();
			repeat (g[2:0]) @(posedge clk);
			u_far.send(q[i]);
		end
	endtask : send_frame
	// cycles until handler pulse, 200 if none; looks in the calling cycle first
	task automatic wait_hdl(output int n);
		n = 0;
		#1;
		while (!handler_q && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask : wait_hdl
	// read answers, compared one cycle after the strobe
	always @(posedge clk) begin
		rd_seen <= rd_en;
		stall <= rnd() > 32'hA000_0000;
		if (rd_seen) begin
			cmp(rd_data_q, exp_q.pop_front());
		end
	end
	initial begin
		#300000;
		n_errors++;
		give_verdict();
	end
	initial begin
		int n;
		logic [15:0] c;
		string s;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(`MB_REG_CTRL, `MB_CTRL_RST);
		rd(`MB_REG_ATO, AT);
		rd(`MB_REG_STAT, 32'h0);
		wr(5'h14, 32'hFFFF_FFFF);
		rd(5'h14, 32'h0);
		rd(`MB_REG_MASK, 32'h0);
		wr(`MB_REG_MASK, 32'h3F);
		for (int k = 0; k < 4; k++) begin
			fr = {(k == 1) ? 8'h02 : 8'h01, (k == 2) ? 8'h07 : 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
			c = crc16(fr);
			fr.push_back(c[7:0] ^ ((k == 3) ? 8'h01 : 8'h00));
			fr.push_back(c[15:8]);
			send_frame(fr);
			wait_hdl(n);
			cmp(k == 0 ? 32'(n >= 50 && n <= 54) : 32'(n), k == 0 ? 32'h1 : 32'd200);
			rd(`MB_REG_STAT, k == 0 ? 32'h1 : 32'h2 << k);
			cmp({31'h0, irq_q}, 32'h1);
			wr(`MB_REG_STAT, 32'h3F);
			rd(`MB_REG_STAT, 32'h0);
			cmp({31'h0, irq_q}, 32'h0);
		end
		u_far.send(8'h01);
		u_far.send(8'h03);
		repeat (30) @(posedge clk);
		u_far.send(8'h00);
		wait_hdl(n);
		cmp(n, 200);
		rd(`MB_REG_STAT, 32'h2);
		wr(`MB_REG_STAT, 32'h3F);
		wr(`MB_REG_CTRL, 32'h104);
		s = ":010300000001FB\r\n";
		fr.delete();
		foreach (s[i]) fr.push_back(s[i]);
		send_frame(fr);
		wait_hdl(n);
		cmp(32'(n <= 2), 32'h1);
		rd(`MB_REG_STAT, 32'h1);
		wr(`MB_REG_STAT, 32'h3F);
		send_frame('{8'h3A, 8'h30, 8'h31});
		wait_hdl(n);
		rd(`MB_REG_STAT, 32'h2);
		wr(`MB_REG_STAT, 32'h3F);
		for (int m = 0; m < 2; m++) begin
			u_far.got.delete();
			wr(`MB_REG_CTRL, m ? 32'h103 : 32'h101);
			fr = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10};
			c = crc16(fr);
			fr.push_back(c[7:0]);
			fr.push_back(c[15:8]);
			s = ":010100000010EE\r\n";
			if (m) begin
				fr.delete();
				foreach (s[i]) fr.push_back(s[i]);
			end
			n = 0;
			while (u_far.got.size() < fr.size() && n < 2000) begin
				@(posedge clk);
				n++;
			end
			cmp(32'(n < 32'(PC) + 200), 32'h1);
			foreach (fr[i]) cmp({24'h0, u_far.got[i]}, {24'h0, fr[i]});
			rd(`MB_REG_STAT, 32'h20);
			wr(`MB_REG_STAT, 32'h3F);
		end
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
